// ==== inc/baa_pkg.sv ====
// Constants, types and helper functions of the blocked array address unit
package baa_pkg;

  // ****************************************************************
  // Operand and result widths
  // ****************************************************************
  localparam int OPERAND_W  = 64;
  localparam int OFFSET_W   = 32;
  localparam int DIM_CODE_W = 3;
  localparam int DEST_IDX_W = 5;

  // ****************************************************************
  // Integer coordinate fields of the packed first source operand
  // ****************************************************************
  localparam int X_INT_LSB  = 11;
  localparam int Y_INT_LSB  = 32;
  localparam int Z_INT_LSB  = 55;
  localparam int XY_INT_W   = 11;
  localparam int Z_INT_W    = 9;

  // ****************************************************************
  // Coordinate slices and blocked offset positions
  // ****************************************************************
  localparam int LOW_XY_W   = 2;
  localparam int MID_W      = 4;
  localparam int MID_LSB    = 2;
  localparam int Z_MID_LSB  = 1;
  localparam int UPPER_LSB  = 6;
  localparam int UPPER_W    = 5;
  localparam int Z_UP_LSB   = 5;
  localparam int Z_UP_W     = 4;
  localparam int POS_X_LO   = 0;
  localparam int POS_Y_LO   = 2;
  localparam int POS_Z_LO   = 4;
  localparam int POS_X_MID  = 5;
  localparam int POS_Y_MID  = 9;
  localparam int POS_Z_MID  = 13;
  localparam int POS_UPPER  = 17;

  // ****************************************************************
  // Dimension code limits
  // ****************************************************************
  localparam logic [DIM_CODE_W-1:0] DIM_CODE_MAX = 3'h5;
  localparam logic [DIM_CODE_W-1:0] DIM_CODE_MIN = 3'h0;

  typedef enum logic [1:0] {
    BAA_ELEM_BYTE = 2'b00,
    BAA_ELEM_HALF = 2'b01,
    BAA_ELEM_WORD = 2'b10
  } baa_elem_t;

  // Codes six and seven act as five; upper operand bits are ignored
  function automatic logic [DIM_CODE_W-1:0] baa_dim_clamp(
    input logic [OPERAND_W-1:0] op
  );
    logic [DIM_CODE_W-1:0] code;
    code = op[DIM_CODE_W-1:0];
    baa_dim_clamp = (code > DIM_CODE_MAX) ? DIM_CODE_MAX : code;
  endfunction : baa_dim_clamp

  // Element scaling shift: none, one or two places
  function automatic logic [1:0] baa_elem_shift(input logic [1:0] elem);
    case (elem)
      BAA_ELEM_HALF: baa_elem_shift = 2'h1;
      BAA_ELEM_WORD: baa_elem_shift = 2'h2;
      default:       baa_elem_shift = 2'h0;
    endcase
  endfunction : baa_elem_shift

endpackage : baa_pkg

// ==== design/baa_interleave.sv ====
// Combinational interleaver from packed coordinates to blocked offset
`timescale 1ns/10ps
`default_nettype none

module baa_interleave
  import baa_pkg::*;
(
  // Operands
  input  wire logic [OPERAND_W-1:0]  coord_operand,
  input  wire logic [DIM_CODE_W-1:0] dim_code,
  // Offset before element scaling
  output logic      [OFFSET_W-1:0]   blocked_offset
);

  logic [XY_INT_W-1:0] x_int;
  logic [XY_INT_W-1:0] y_int;
  logic [Z_INT_W-1:0]  z_int;
  logic [UPPER_W-1:0]  upper_mask;
  logic [OFFSET_W-1:0] x_up;
  logic [OFFSET_W-1:0] y_up;
  logic [OFFSET_W-1:0] z_up;
  logic [OFFSET_W-1:0] dim_double;

  // Fraction bits never reach the offset
  assign x_int = coord_operand[X_INT_LSB +: XY_INT_W];
  assign y_int = coord_operand[Y_INT_LSB +: XY_INT_W];
  assign z_int = coord_operand[Z_INT_LSB +: Z_INT_W];

  // Upper x and y bits beyond the dimension are masked off
  assign upper_mask = ~({UPPER_W{1'b1}} << dim_code);
  assign dim_double = OFFSET_W'({dim_code, 1'b0});

  always_comb begin
    x_up = OFFSET_W'(x_int[UPPER_LSB +: UPPER_W] & upper_mask);
    y_up = OFFSET_W'(y_int[UPPER_LSB +: UPPER_W] & upper_mask);
    z_up = OFFSET_W'(z_int[Z_UP_LSB +: Z_UP_W]);
    blocked_offset = '0;
    // Small 4x4x2 block: 64 bytes of halfword data
    blocked_offset[POS_X_LO +: LOW_XY_W] = x_int[LOW_XY_W-1:0];
    blocked_offset[POS_Y_LO +: LOW_XY_W] = y_int[LOW_XY_W-1:0];
    blocked_offset[POS_Z_LO]             = z_int[0];
    // Mid block: 64x64x32 elements
    blocked_offset[POS_X_MID +: MID_W] = x_int[MID_LSB +: MID_W];
    blocked_offset[POS_Y_MID +: MID_W] = y_int[MID_LSB +: MID_W];
    blocked_offset[POS_Z_MID +: MID_W] = z_int[Z_MID_LSB +: MID_W];
    // Upper fields stack by n; nothing lands above z upper
    blocked_offset = blocked_offset
                   | (x_up << POS_UPPER)
                   | (y_up << (OFFSET_W'(POS_UPPER) + OFFSET_W'(dim_code)))
                   | (z_up << (OFFSET_W'(POS_UPPER) + dim_double));
  end

endmodule : baa_interleave

`default_nettype wire

// ==== design/baa_array_addr.sv ====
// Blocked array address execution stage with one cycle of latency
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Dimension code 0..5 gives 64..2048 elements
// - Codes six, seven act as five
// - Three variants differ only in element size
// - Shift offset left 0, 1 or 2
// - Bits above z upper field are zero
// - Excess x and y integer bits ignored
// - Code zero puts z[8:5] at 20:17
// - Eleven x, y and nine z bits
// - All coordinates from one 64-bit operand
// - Offset written to destination register
// - Halfword offsets group 64-byte and 256-Kbyte blocks
module baa_array_addr
  import baa_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Issue from the integer pipeline
  input  wire logic                  issue_valid,
  input  wire logic [1:0]            issue_elem_size,
  input  wire logic [OPERAND_W-1:0]  first_source_operand,
  input  wire logic [OPERAND_W-1:0]  second_source_operand,
  input  wire logic [DEST_IDX_W-1:0] issue_dest_index,
  // Destination register write
  output logic                       dest_write_en_reg,
  output logic      [DEST_IDX_W-1:0] dest_index_reg,
  output logic      [OPERAND_W-1:0]  dest_value_reg,
  output logic                       exception_reg
);

  // ****************************************************************
  // Operand decode
  // ****************************************************************
  logic [DIM_CODE_W-1:0] dim_code;
  logic [OFFSET_W-1:0]   blocked_offset;
  logic [1:0]            elem_shift;
  logic [OPERAND_W-1:0]  dest_value_next;

  // Only the low three bits decide; the rest are don't-care
  assign dim_code   = baa_dim_clamp(second_source_operand);
  assign elem_shift = baa_elem_shift(issue_elem_size);

  baa_interleave baa_interleave_inst (
    .coord_operand  (first_source_operand),
    .dim_code       (dim_code),
    .blocked_offset (blocked_offset)
  );

  // Vacated low bits fill with zeros
  assign dest_value_next = OPERAND_W'(blocked_offset) << elem_shift;

  // ****************************************************************
  // Result registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_write_en_reg <= 1'b0;
    end else begin
      dest_write_en_reg <= issue_valid;
    end
  end

  // Data flops load on issue only to save toggling
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_index_reg <= '0;
      dest_value_reg <= '0;
    end else if (issue_valid) begin
      dest_index_reg <= issue_dest_index;
      dest_value_reg <= dest_value_next;
    end
  end

  // Any operand pattern is legal: no trap is ever reported
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      exception_reg <= 1'b0;
    end else begin
      exception_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************
  logic [OPERAND_W-1:0] top_bit_next;
  logic [OPERAND_W-1:0] live_mask_reg;

  // Lowest dead bit: just above z upper field, plus scaling
  assign top_bit_next = OPERAND_W'(POS_UPPER + Z_UP_W)
                      + OPERAND_W'({dim_code, 1'b0})
                      + OPERAND_W'(elem_shift);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      live_mask_reg <= '0;
    end else if (issue_valid) begin
      live_mask_reg <= ~({OPERAND_W{1'b1}} << top_bit_next);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!reset_n);

  write_follows_issue_a: assert property (
    issue_valid |=> dest_write_en_reg &&
                    dest_index_reg == $past(issue_dest_index)
  ) else $error("destination write did not follow issue");

  no_spurious_write_a: assert property (
    !issue_valid |=> !dest_write_en_reg
  ) else $error("destination write without issue");

  no_trap_illegal_a: assert property (
    issue_valid && second_source_operand[DIM_CODE_W-1:0] > DIM_CODE_MAX
      |=> dest_write_en_reg && !exception_reg ##1 !exception_reg
  ) else $error("illegal dimension code disturbed completion");

  clamp_to_five_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] > DIM_CODE_MAX
      |=> dest_value_reg[30:27] == $past(first_source_operand[63:60]) &&
          dest_value_reg[26:22] == $past(first_source_operand[42:38])
  ) else $error("codes six or seven not treated as five");

  dim_zero_z_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MIN
      |=> dest_value_reg[20:17] == $past(first_source_operand[63:60])
  ) else $error("code zero z upper bits misplaced");

  dim_one_upper_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == 3'h1
      |=> dest_value_reg[17] == $past(first_source_operand[17]) &&
          dest_value_reg[18] == $past(first_source_operand[38]) &&
          dest_value_reg[22:19] == $past(first_source_operand[63:60])
  ) else $error("code one upper fields misplaced");

  upper_ignored_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MIN
      |=> dest_value_reg[OPERAND_W-1:21] == '0 &&
          dest_value_reg[16:13] == $past(first_source_operand[59:56])
  ) else $error("excess x or y bits reached the result");

  above_z_zero_a: assert property (
    dest_write_en_reg |-> (dest_value_reg & ~live_mask_reg) == '0
  ) else $error("bits above z upper field not zero");

  byte_interleave_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE
      |=> dest_value_reg[1:0] == $past(first_source_operand[12:11]) &&
          dest_value_reg[3:2] == $past(first_source_operand[33:32]) &&
          dest_value_reg[4]   == $past(first_source_operand[55]) &&
          dest_value_reg[8:5] == $past(first_source_operand[16:13]) &&
          dest_value_reg[12:9] == $past(first_source_operand[37:34])
  ) else $error("byte variant interleave wrong");

  half_block_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_HALF
      |=> dest_value_reg[5:0] == {$past(first_source_operand[55]),
                                  $past(first_source_operand[33:32]),
                                  $past(first_source_operand[12:11]), 1'b0}
  ) else $error("halfword 64-byte block wrong");

  word_scale_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_WORD
      |=> dest_value_reg[1:0] == 2'h0 &&
          dest_value_reg[3:2] == $past(first_source_operand[12:11]) &&
          dest_value_reg[14:7] == $past({first_source_operand[37:34],
                                         first_source_operand[16:13]})
  ) else $error("word variant scaling wrong");

  single_operand_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    $past(issue_valid) && $past(issue_elem_size) == BAA_ELEM_BYTE &&
    $stable(first_source_operand) && $stable(second_source_operand[2:0])
      |=> $stable(dest_value_reg)
  ) else $error("same operands gave a different offset");

  value_hold_a: assert property (
    !issue_valid
      |=> $stable(dest_value_reg) && $stable(dest_index_reg)
  ) else $error("result changed without issue");

  z_mid_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE
      |=> dest_value_reg[16:13] == $past(first_source_operand[59:56])
  ) else $error("z mid field misplaced");

  size_three_byte_a: assert property (
    issue_valid && issue_elem_size == 2'h3
      |=> dest_value_reg[1:0] == $past(first_source_operand[12:11]) &&
          dest_value_reg[4]   == $past(first_source_operand[55]) &&
          dest_value_reg[8:5] == $past(first_source_operand[16:13])
  ) else $error("spare size code not handled as byte");

  // ****************************************************************
  // Upper field placement for each dimension code
  // ****************************************************************
  dim_two_upper_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == 3'h2
      |=> dest_value_reg[18:17] == $past(first_source_operand[18:17]) &&
          dest_value_reg[20:19] == $past(first_source_operand[39:38]) &&
          dest_value_reg[24:21] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:25] == '0
  ) else $error("code two upper fields misplaced");

  dim_three_upper_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == 3'h3
      |=> dest_value_reg[19:17] == $past(first_source_operand[19:17]) &&
          dest_value_reg[22:20] == $past(first_source_operand[40:38]) &&
          dest_value_reg[26:23] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:27] == '0
  ) else $error("code three upper fields misplaced");

  dim_four_upper_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == 3'h4
      |=> dest_value_reg[20:17] == $past(first_source_operand[20:17]) &&
          dest_value_reg[24:21] == $past(first_source_operand[41:38]) &&
          dest_value_reg[28:25] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:29] == '0
  ) else $error("code four upper fields misplaced");

  dim_five_upper_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MAX
      |=> dest_value_reg[21:17] == $past(first_source_operand[21:17]) &&
          dest_value_reg[26:22] == $past(first_source_operand[42:38]) &&
          dest_value_reg[30:27] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:31] == '0
  ) else $error("code five upper fields misplaced");

  half_mid_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_HALF
      |=> dest_value_reg[9:6]   == $past(first_source_operand[16:13]) &&
          dest_value_reg[13:10] == $past(first_source_operand[37:34]) &&
          dest_value_reg[17:14] == $past(first_source_operand[59:56])
  ) else $error("halfword mid fields wrong");

  half_dim_zero_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_HALF &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MIN
      |=> dest_value_reg[21:18] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:22] == '0
  ) else $error("halfword code zero top wrong");

  half_dim_five_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_HALF &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MAX
      |=> dest_value_reg[22:18] == $past(first_source_operand[21:17]) &&
          dest_value_reg[27:23] == $past(first_source_operand[42:38]) &&
          dest_value_reg[31:28] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:32] == '0
  ) else $error("halfword code five upper fields wrong");

  word_dim_zero_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_WORD &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MIN
      |=> dest_value_reg[22:19] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:23] == '0
  ) else $error("word code zero top wrong");

  word_dim_five_a: assert property (
    issue_valid && issue_elem_size == BAA_ELEM_WORD &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MAX
      |=> dest_value_reg[23:19] == $past(first_source_operand[21:17]) &&
          dest_value_reg[28:24] == $past(first_source_operand[42:38]) &&
          dest_value_reg[32:29] == $past(first_source_operand[63:60]) &&
          dest_value_reg[OPERAND_W-1:33] == '0
  ) else $error("word code five upper fields wrong");

  // ****************************************************************
  // Coverage
  // ****************************************************************
  byte_issue_c: cover property (
    issue_valid && issue_elem_size == BAA_ELEM_BYTE ##1 dest_write_en_reg);

  half_issue_c: cover property (
    issue_valid && issue_elem_size == BAA_ELEM_HALF ##1 dest_write_en_reg);

  word_max_dim_c: cover property (
    issue_valid && issue_elem_size == BAA_ELEM_WORD &&
    second_source_operand[DIM_CODE_W-1:0] == DIM_CODE_MAX);

  illegal_code_c: cover property (
    issue_valid && second_source_operand[DIM_CODE_W-1:0] > DIM_CODE_MAX);

  back_to_back_c: cover property (issue_valid [*3]);

endmodule : baa_array_addr

`default_nettype wire

// ==== test/blocked_array_address_gen_bench.sv ====
// Self-checking bench of the blocked array address stage
`timescale 1ns/10ps
`default_nettype none

module blocked_array_address_gen_bench
  import baa_pkg::*;
;
  logic                  sys_clk;
  logic                  reset_n;
  logic                  issue_valid;
  logic [1:0]            issue_elem_size;
  logic [OPERAND_W-1:0]  first_source_operand;
  logic [OPERAND_W-1:0]  second_source_operand;
  logic [DEST_IDX_W-1:0] issue_dest_index;
  logic                  dest_write_en_reg;
  logic [DEST_IDX_W-1:0] dest_index_reg;
  logic [OPERAND_W-1:0]  dest_value_reg;
  logic                  exception_reg;
  logic [68:0]           exp_q[$];
  logic [68:0]           last = '0;
  int                    fail_count;
  int                    n_checks;
  integer                seed;

  baa_array_addr baa_array_addr_inst (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .issue_valid          (issue_valid),
    .issue_elem_size      (issue_elem_size),
    .first_source_operand (first_source_operand),
    .second_source_operand(second_source_operand),
    .issue_dest_index     (issue_dest_index),
    .dest_write_en_reg    (dest_write_en_reg),
    .dest_index_reg       (dest_index_reg),
    .dest_value_reg       (dest_value_reg),
    .exception_reg        (exception_reg)
  );

  always #5 sys_clk = ~sys_clk;

  // ****************************************************************
  // Reference model, written bit field by bit field
  // ****************************************************************
  function automatic logic [63:0] model(logic [63:0] a, logic [63:0] b, logic [1:0] sz);
    int          n;
    logic [63:0] x;
    logic [63:0] y;
    logic [63:0] z;
    logic [63:0] m;
    logic [63:0] r;
    n = (b[2:0] > 3'h5) ? 5 : int'(b[2:0]);
    x = {53'h0, a[21:11]};
    y = {53'h0, a[42:32]};
    z = {55'h0, a[63:55]};
    m = (64'h1 << n) - 64'h1;
    r = (x & 64'h3) | ((y & 64'h3) << 2) | ((z & 64'h1) << 4);
    r = r | (((x >> 2) & 64'hf) << 5) | (((y >> 2) & 64'hf) << 9);
    r = r | (((z >> 1) & 64'hf) << 13) | (((x >> 6) & m) << 17);
    r = r | (((y >> 6) & m) << (17 + n)) | (((z >> 5) & 64'hf) << (17 + 2 * n));
    return r << ((sz == 2'h1) ? 1 : (sz == 2'h2) ? 2 : 0);
  endfunction : model

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic issue(logic [1:0] sz, logic [63:0] a, logic [63:0] b, logic [4:0] ix);
    @(posedge sys_clk);
    issue_valid           <= 1'b1;
    issue_elem_size       <= sz;
    first_source_operand  <= a;
    second_source_operand <= b;
    issue_dest_index      <= ix;
    exp_q.push_back({ix, model(a, b, sz)});
  endtask : issue

  // Garbage on operands while idle must not disturb held results
  task automatic idle(int cycles);
    repeat (cycles) begin
      @(posedge sys_clk);
      issue_valid           <= 1'b0;
      first_source_operand  <= {$random(seed), $random(seed)};
      second_source_operand <= {$random(seed), $random(seed)};
    end
  endtask : idle

  // ****************************************************************
  // Result monitor, away from the sampling edge
  // ****************************************************************
  always @(negedge sys_clk) begin
    if (reset_n !== 1'b1) begin
      check("reset outputs", {dest_write_en_reg, dest_index_reg, exception_reg}, 64'h0);
      check("reset value", dest_value_reg, 64'h0);
    end else begin
      check("exception", {63'h0, exception_reg}, 64'h0);
      if (dest_write_en_reg === 1'b1) begin
        if (exp_q.size() == 0) begin
          check("spurious write", 64'h1, 64'h0);
        end else begin
          last = exp_q.pop_front();
          check("dest value", dest_value_reg, last[63:0]);
          check("dest index", {59'h0, dest_index_reg}, {59'h0, last[68:64]});
        end
      end else begin
        check("held value", dest_value_reg, last[63:0]);
      end
    end
  end

  initial begin
    for (int i = 0; i < 100000; i++)
      @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    sys_clk               = 1'b0;
    reset_n               = 1'b0;
    issue_valid           = 1'b0;
    issue_elem_size       = 2'h0;
    first_source_operand  = 64'h0;
    second_source_operand = 64'h0;
    issue_dest_index      = 5'h0;
    fail_count            = 0;
    n_checks              = 0;
    seed                  = 32'h95cd;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Every code with every size, back to back, junk in ignored bits
    for (int c = 0; c < 8; c++)
      for (int s = 0; s < 4; s++)
        issue(s[1:0], {$random(seed), $random(seed)},
              {$random(seed), $random(seed)} & ~64'h7 | c, 5'($random(seed)));
    idle(2);
    $display("Test code and size sweep done");
    // Code zero places top z bits right above the mid fields
    issue(2'h0, {9'h1e0, 55'h0}, 64'h0, 5'h1);
    issue(2'h0, 64'hffff_ffff_ffff_ffff, 64'h8, 5'h2);
    // Widest field with word scaling leaves everything above zero
    issue(2'h2, 64'hffff_ffff_ffff_ffff, 64'h5, 5'h3);
    issue(2'h1, 64'hffff_ffff_ffff_ffff, 64'h7, 5'h4);
    issue(2'h2, {9'h1ff, 12'h0, 11'h7ff, 10'h0, 11'h7ff, 11'h0}, 64'h3, 5'h5);
    // Same coordinates twice; only ignored code bits differ
    issue(2'h0, 64'h0123_4567_89ab_cdef, 64'h2, 5'h6);
    issue(2'h0, 64'h0123_4567_89ab_cdef, 64'hf0_0000_0002, 5'h7);
    idle(2);
    $display("Test field boundaries done");
    // Random traffic with random gaps
    for (int i = 0; i < 300; i++) begin
      if ($random(seed) & 1)
        issue(2'($random(seed)), {$random(seed), $random(seed)},
              {$random(seed), $random(seed)}, 5'($random(seed)));
      else
        idle(1 + ($random(seed) & 3));
    end
    idle(3);
    check("pending results", exp_q.size(), 64'h0);
    $display("Test random traffic done");
    end_of_test();
  end
endmodule : blocked_array_address_gen_bench

`default_nettype wire
